// [core/cfmon_pkg.sv]
// Constants, carriers and threshold decoders for the clock fault monitor.
// How it works
// - Four monitor kinds: edge absence, drift, PLL lock fault, reference absence.
// - Each defect has a live status bit, high only while the defect lasts.
// - Each live bit has a sticky notify bit that holds until cleared.
// - A notify bit captures only while its enable bit is set.
// - Each alarm pin shows one selected live or notify bit or an OR of a set.
// - Fixed fault pins carry hard-wired clock defect information.
// - Selected notify bits drive the active-low interrupt output.
// - Live and notify bits are readable by registers and alarm pins.
// - Input monitors watch the divided input clocks.
// - Edge absence asserts after a programmed count of consecutive missing edges.
// - Release is a candidate once edges return below the clear count.
// - Release waits a qualifying time of 2 ms, 100 ms, 200 ms or 1 s.
// - Drift is measured against a selectable golden reference clock.
// - Lock fault compares feedback and reference frequency of each PLL.
// - Loss of the reference oscillator clock is its own defect.
// - Fine drift uses 2 ppm steps, 2 to 510 ppm, separate set and clear.
// - Coarse drift uses 100 ppm steps, 100 to 1600 ppm, separate set and clear.
package cfmon_pkg;
  localparam int NUM_IN  = 4;
  localparam int NUM_CLK = 5;
  localparam int NUM_PLL = 4;
  localparam int NUM_DEF = 19;
  localparam int NUM_PIN = 13;
  localparam int DEF_FINE = 4;
  localparam int DEF_CRS  = 9;
  localparam int DEF_LOCK = 14;
  localparam int DEF_XO   = 18;
  localparam logic [7:0] OFF_STATUS    = 8'h00;
  localparam logic [7:0] OFF_NOTIFY    = 8'h04;
  localparam logic [7:0] OFF_NOTIFY_EN = 8'h08;
  localparam logic [7:0] OFF_INT_MASK  = 8'h0c;
  localparam logic [7:0] OFF_ALARM0    = 8'h10;
  localparam logic [7:0] OFF_ALARM1    = 8'h14;
  localparam logic [7:0] OFF_VALTIME   = 8'h18;
  localparam logic [7:0] OFF_GOLDEN    = 8'h1c;
  localparam logic [7:0] OFF_CL_CFG    = 8'h20;
  localparam logic [7:0] OFF_FD_WIN    = 8'h34;
  localparam logic [7:0] OFF_FD_THR    = 8'h38;
  localparam logic [7:0] OFF_LL_WIN    = 8'h3c;
  localparam logic [7:0] OFF_LL_THR    = 8'h40;
  localparam logic [7:0] OFF_FD_EXP    = 8'h44;
  localparam logic [7:0] OFF_ARR_SPAN  = 8'h14;
  localparam int ALM_SEL_LSB = 24;
  localparam int ALM_LIVE    = 30;
  localparam int ALM_OR      = 31;
  localparam int FINE_SET_LSB = 0;
  localparam int FINE_CLR_LSB = 8;
  localparam int CRS_SET_LSB  = 16;
  localparam int CRS_CLR_LSB  = 20;
  localparam int LL_SET_LSB   = 0;
  localparam int LL_CLR_LSB   = 4;
  localparam int COARSE_SHIFT = 4;
  localparam logic [31:0] RST_ZERO   = 32'h0000_0000;
  localparam logic [31:0] RST_CL_CFG = 32'h0102_0010;
  localparam logic [15:0] FINE_STEP  = 16'h0014;
  localparam logic [15:0] CRS_STEP   = 16'h03e8;
  localparam logic [23:0] PPM_SCALE  = 24'h98_9680;
  localparam int CLK_PERIOD_NS = 25;
  localparam int VAL_NS_0 = 2_000_000;
  localparam int VAL_NS_1 = 100_000_000;
  localparam int VAL_NS_2 = 200_000_000;
  localparam int VAL_NS_3 = 1_000_000_000;
  localparam int VAL_CYC_0 = (VAL_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VAL_CYC_1 = (VAL_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VAL_CYC_2 = (VAL_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VAL_CYC_3 = (VAL_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef struct packed {
    logic [7:0]  clear;
    logic [7:0]  trigger;
    logic [15:0] period;
  } cfmon_edge_cfg_s;
  typedef struct packed {
    logic [23:0] window;
    logic [23:0] expected;
    logic [15:0] set_thr;
    logic [15:0] clr_thr;
  } cfmon_cmp_cfg_s;
  // Thresholds are in tenths of a ppm; a zero code would flag every window.
  function automatic logic [15:0] cfmon_fine_thr(input logic [7:0] code);
    cfmon_fine_thr = FINE_STEP * 16'((code == 8'h00) ? 8'h01 : code);
  endfunction : cfmon_fine_thr
  function automatic logic [15:0] cfmon_crs_thr(input logic [3:0] code);
    cfmon_crs_thr = CRS_STEP * 16'({1'b0, code} + 5'h01);
  endfunction : cfmon_crs_thr
endpackage : cfmon_pkg

// [core/cfmon_edge_mon.sv]
// Missing-edge monitor with qualified release for one divided clock.
`timescale 1ns/1ps
module cfmon_edge_mon (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // Monitored clock and settings
  input  wire logic                       clk_edge,
  input  wire cfmon_pkg::cfmon_edge_cfg_s cfg,
  input  wire logic [25:0]                wait_cyc,
  // Result
  output logic                            absent
);
  typedef enum logic [1:0] {EM_OK, EM_LOST, EM_QUAL} cfmon_edge_st_e;
  cfmon_edge_st_e state;
  cfmon_edge_st_e next_state;
  logic [15:0]    idle_cnt;
  logic [7:0]     miss;
  logic [25:0]    qual;
  logic           miss_tick;

  // One missing edge is one nominal period without a rising edge.
  assign miss_tick = !clk_edge && (cfg.period != 16'h0000) &&
                     (idle_cnt >= cfg.period - 16'h0001);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) idle_cnt <= 16'h0000;
    else if (clk_edge || miss_tick) idle_cnt <= 16'h0000;
    else idle_cnt <= idle_cnt + 16'h0001;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) miss <= 8'h00;
    else if (clk_edge) miss <= 8'h00;
    else if (miss_tick && miss != 8'hff) miss <= miss + 8'h01;
  end

  always_comb begin
    next_state = state;
    case (state)
      EM_OK:   if (cfg.trigger != 8'h00 && miss >= cfg.trigger) next_state = EM_LOST;
      EM_LOST: if (clk_edge) next_state = EM_QUAL;
      EM_QUAL: begin
        if (miss >= cfg.clear) next_state = EM_LOST;
        else if (qual >= wait_cyc - 26'h1) next_state = EM_OK;
      end
      default: next_state = EM_OK;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) qual <= 26'h0;
    else if (state != EM_QUAL) qual <= 26'h0;
    else qual <= qual + 26'h1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state  <= EM_OK;
      absent <= 1'b0;
    end else begin
      state  <= next_state;
      absent <= next_state != EM_OK;
    end
  end
endmodule : cfmon_edge_mon

// [core/cfmon_freq_cmp.sv]
// Windowed frequency comparator with separate set and clear thresholds.
`timescale 1ns/1ps
module cfmon_freq_cmp (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      nrst,
  // Edges and settings
  input  wire logic                      enable,
  input  wire logic                      ref_edge,
  input  wire logic                      test_edge,
  input  wire cfmon_pkg::cfmon_cmp_cfg_s cfg,
  // Result
  output logic                           fault
);
  logic [23:0] ref_cnt;
  logic [23:0] test_cnt;
  logic [23:0] next_test;
  logic [23:0] dev;
  logic [47:0] dev_scaled;
  logic [47:0] set_lim;
  logic [47:0] clr_lim;
  logic        window_end;

  // Deviation in tenths of a ppm is compared by cross multiplication,
  // which trades three multipliers for a divider.
  always_comb begin
    next_test  = test_cnt + {23'h0, test_edge};
    window_end = ref_edge && (ref_cnt >= cfg.window - 24'h1);
    dev = (next_test >= cfg.expected) ? next_test - cfg.expected : cfg.expected - next_test;
    dev_scaled = 48'(dev) * 48'(cfmon_pkg::PPM_SCALE);
    set_lim    = 48'(cfg.set_thr) * 48'(cfg.expected);
    clr_lim    = 48'(cfg.clr_thr) * 48'(cfg.expected);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_cnt  <= 24'h0;
      test_cnt <= 24'h0;
    end else if (!enable || window_end) begin
      ref_cnt  <= 24'h0;
      test_cnt <= 24'h0;
    end else begin
      ref_cnt  <= ref_cnt + {23'h0, ref_edge};
      test_cnt <= next_test;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) fault <= 1'b0;
    else if (!enable) fault <= 1'b0;
    else if (window_end) begin
      if (!fault && dev_scaled >= set_lim) fault <= 1'b1;
      else if (fault && dev_scaled < clr_lim) fault <= 1'b0;
    end
  end
endmodule : cfmon_freq_cmp

// [core/cfmon_top.sv]
// Clock fault monitor: pin sampling, monitors, notify logic and registers.
`timescale 1ns/1ps
module cfmon_top #(
  parameter logic [25:0] VAL_CYC_2MS   = 26'(cfmon_pkg::VAL_CYC_0),
  parameter logic [25:0] VAL_CYC_100MS = 26'(cfmon_pkg::VAL_CYC_1),
  parameter logic [25:0] VAL_CYC_200MS = 26'(cfmon_pkg::VAL_CYC_2),
  parameter logic [25:0] VAL_CYC_1S    = 26'(cfmon_pkg::VAL_CYC_3)
) (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  // Register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  // Monitored clocks, inputs already past their dividers
  input  wire logic [3:0]  IN_CLK,
  input  wire logic        XO_CLK,
  input  wire logic [3:0]  PLL_REF,
  input  wire logic [3:0]  PLL_FB,
  // Alarm and interrupt pins
  output logic      [1:0]  ALARM,
  output logic      [1:0]  FIXED_ALARM,
  output logic             INT_N
);
  localparam int ND = cfmon_pkg::NUM_DEF;
  localparam int NC = cfmon_pkg::NUM_CLK;
  localparam int NP = cfmon_pkg::NUM_PLL;

  logic [cfmon_pkg::NUM_PIN-1:0] pin_s1;
  logic [cfmon_pkg::NUM_PIN-1:0] pin_s2;
  logic [cfmon_pkg::NUM_PIN-1:0] pin_s3;
  logic [cfmon_pkg::NUM_PIN-1:0] edges;
  logic [NC-1:0]                 clk_edges;
  logic [NC-1:0]                 edge_abs;
  logic [NC-1:0]                 fine_f;
  logic [NC-1:0]                 crs_f;
  logic [NP-1:0]                 lock_f;
  logic [ND-1:0]                 live;
  logic [ND-1:0]                 notify;
  logic [ND-1:0]                 notify_en;
  logic [ND-1:0]                 int_mask;
  logic [31:0]                   alarm_cfg [2];
  logic [9:0]                    valtime;
  logic [2:0]                    golden;
  logic [31:0]                   cl_cfg [NC];
  logic [23:0]                   fd_exp [NC];
  logic [23:0]                   fd_win;
  logic [23:0]                   fd_thr;
  logic [23:0]                   ll_win;
  logic [5:0]                    ll_thr;
  logic [25:0]                   wait_tab [4];
  logic                          golden_edge;
  logic [7:0]                    arr_off;
  logic [2:0]                    arr_idx;
  logic                          in_cl;
  logic                          in_exp;
  logic [31:0]                   read_word;
  logic [ND-1:0]                 w1c;

  // Clock pins come from other domains; the second and third stages feed the edge detector.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= {PLL_FB, PLL_REF, XO_CLK, IN_CLK};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Monitors see rising edges only, so clocks must stay below half CLK_SYS.
  assign edges     = pin_s2 & ~pin_s3;
  assign clk_edges = edges[NC-1:0];

  assign wait_tab[0] = VAL_CYC_2MS;
  assign wait_tab[1] = VAL_CYC_100MS;
  assign wait_tab[2] = VAL_CYC_200MS;
  assign wait_tab[3] = VAL_CYC_1S;

  // Index 4 of the edge monitors watches the reference oscillator.
  generate
    for (genvar i = 0; i < NC; i++) begin : g_edge
      cfmon_edge_mon u_edge (
        .clk      (CLK_SYS),
        .nrst     (NRST),
        .clk_edge (clk_edges[i]),
        .cfg      (cfmon_pkg::cfmon_edge_cfg_s'(cl_cfg[i])),
        .wait_cyc (wait_tab[valtime[2*i +: 2]]),
        .absent   (edge_abs[i])
      );
    end
  endgenerate

  always_comb begin
    golden_edge = 1'b0;
    for (int i = 0; i < NC; i++) begin
      if (golden == 3'(i)) golden_edge = clk_edges[i];
    end
  end

  // The golden clock never reports drift against itself.
  generate
    for (genvar i = 0; i < NC; i++) begin : g_drift
      cfmon_pkg::cfmon_cmp_cfg_s fine_cfg;
      cfmon_pkg::cfmon_cmp_cfg_s crs_cfg;
      logic                      drift_on;
      assign drift_on         = (fd_win != 24'h0) && (golden != 3'(i));
      assign fine_cfg.window   = fd_win;
      assign fine_cfg.expected = fd_exp[i];
      assign fine_cfg.set_thr  = cfmon_pkg::cfmon_fine_thr(fd_thr[cfmon_pkg::FINE_SET_LSB +: 8]);
      assign fine_cfg.clr_thr  = cfmon_pkg::cfmon_fine_thr(fd_thr[cfmon_pkg::FINE_CLR_LSB +: 8]);
      // The coarse window is shorter, so it reacts faster at lower resolution.
      assign crs_cfg.window   = fd_win >> cfmon_pkg::COARSE_SHIFT;
      assign crs_cfg.expected = fd_exp[i] >> cfmon_pkg::COARSE_SHIFT;
      assign crs_cfg.set_thr  = cfmon_pkg::cfmon_crs_thr(fd_thr[cfmon_pkg::CRS_SET_LSB +: 4]);
      assign crs_cfg.clr_thr  = cfmon_pkg::cfmon_crs_thr(fd_thr[cfmon_pkg::CRS_CLR_LSB +: 4]);
      cfmon_freq_cmp u_fine (
        .clk       (CLK_SYS),
        .nrst      (NRST),
        .enable    (drift_on),
        .ref_edge  (golden_edge),
        .test_edge (clk_edges[i]),
        .cfg       (fine_cfg),
        .fault     (fine_f[i])
      );
      cfmon_freq_cmp u_crs (
        .clk       (CLK_SYS),
        .nrst      (NRST),
        .enable    (drift_on && (crs_cfg.window != 24'h0)),
        .ref_edge  (golden_edge),
        .test_edge (clk_edges[i]),
        .cfg       (crs_cfg),
        .fault     (crs_f[i])
      );
    end
  endgenerate

  function automatic logic [15:0] ll_set(input logic [3:0] code);
    case (code)
      4'h0:    ll_set = 16'h0002;
      4'h1:    ll_set = 16'h0004;
      4'h2:    ll_set = 16'h0014;
      4'h3:    ll_set = 16'h0028;
      4'h4:    ll_set = 16'h00c8;
      4'h5:    ll_set = 16'h0190;
      4'h6:    ll_set = 16'h07d0;
      4'h7:    ll_set = 16'h0fa0;
      4'h8:    ll_set = 16'h4e20;
      default: ll_set = 16'h9c40;
    endcase
  endfunction : ll_set

  function automatic logic [15:0] ll_clr(input logic [1:0] code);
    case (code)
      2'h0:    ll_clr = 16'h0002;
      2'h1:    ll_clr = 16'h0004;
      2'h2:    ll_clr = 16'h0014;
      default: ll_clr = 16'h07d0;
    endcase
  endfunction : ll_clr

  // A locked loop sees equal edge counts on reference and feedback.
  generate
    for (genvar p = 0; p < NP; p++) begin : g_lock
      cfmon_pkg::cfmon_cmp_cfg_s ll_cfg;
      assign ll_cfg.window   = ll_win;
      assign ll_cfg.expected = ll_win;
      assign ll_cfg.set_thr  = ll_set(ll_thr[cfmon_pkg::LL_SET_LSB +: 4]);
      assign ll_cfg.clr_thr  = ll_clr(ll_thr[cfmon_pkg::LL_CLR_LSB +: 2]);
      cfmon_freq_cmp u_ll (
        .clk       (CLK_SYS),
        .nrst      (NRST),
        .enable    (ll_win != 24'h0),
        .ref_edge  (edges[NC + p]),
        .test_edge (edges[NC + NP + p]),
        .cfg       (ll_cfg),
        .fault     (lock_f[p])
      );
    end
  endgenerate

  // Defect layout: inputs, fine drift, coarse drift, lock faults, oscillator.
  assign live = {edge_abs[NC-1], lock_f, crs_f, fine_f, edge_abs[NC-2:0]};

  assign w1c = (WR && ADDR == cfmon_pkg::OFF_NOTIFY) ? WDATA[ND-1:0] : '0;

  // A live defect with its enable bit set outweighs a clear in the same cycle.
  generate
    for (genvar d = 0; d < ND; d++) begin : g_notify
      always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) notify[d] <= 1'b0;
        else if (notify_en[d] && live[d]) notify[d] <= 1'b1;
        else if (w1c[d]) notify[d] <= 1'b0;
      end
    end
  endgenerate

  assign arr_off = ADDR - cfmon_pkg::OFF_CL_CFG;
  assign in_cl   = ADDR >= cfmon_pkg::OFF_CL_CFG &&
                   ADDR < cfmon_pkg::OFF_CL_CFG + cfmon_pkg::OFF_ARR_SPAN;
  assign in_exp  = ADDR >= cfmon_pkg::OFF_FD_EXP &&
                   ADDR < cfmon_pkg::OFF_FD_EXP + cfmon_pkg::OFF_ARR_SPAN;
  assign arr_idx = in_cl ? arr_off[4:2] : 3'(8'(ADDR - cfmon_pkg::OFF_FD_EXP) >> 2);

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) notify_en <= '0;
    else if (WR && ADDR == cfmon_pkg::OFF_NOTIFY_EN) notify_en <= WDATA[ND-1:0];
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) int_mask <= '0;
    else if (WR && ADDR == cfmon_pkg::OFF_INT_MASK) int_mask <= WDATA[ND-1:0];
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      alarm_cfg[0] <= cfmon_pkg::RST_ZERO;
      alarm_cfg[1] <= cfmon_pkg::RST_ZERO;
    end else if (WR && ADDR == cfmon_pkg::OFF_ALARM0) alarm_cfg[0] <= WDATA;
    else if (WR && ADDR == cfmon_pkg::OFF_ALARM1) alarm_cfg[1] <= WDATA;
  end

  // Edge absence and drift settings are the host-facing monitor page.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      valtime <= '0;
      golden  <= '0;
      fd_win  <= '0;
      fd_thr  <= '0;
    end else if (WR && ADDR == cfmon_pkg::OFF_VALTIME) valtime <= WDATA[9:0];
    else if (WR && ADDR == cfmon_pkg::OFF_GOLDEN) golden <= WDATA[2:0];
    else if (WR && ADDR == cfmon_pkg::OFF_FD_WIN) fd_win <= WDATA[23:0];
    else if (WR && ADDR == cfmon_pkg::OFF_FD_THR) fd_thr <= WDATA[23:0];
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      ll_win <= '0;
      ll_thr <= '0;
    end else if (WR && ADDR == cfmon_pkg::OFF_LL_WIN) ll_win <= WDATA[23:0];
    else if (WR && ADDR == cfmon_pkg::OFF_LL_THR) ll_thr <= WDATA[5:0];
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < NC; i++) begin
        cl_cfg[i] <= cfmon_pkg::RST_CL_CFG;
        fd_exp[i] <= '0;
      end
    end else if (WR && in_cl) cl_cfg[arr_idx] <= WDATA;
    else if (WR && in_exp) fd_exp[arr_idx] <= WDATA[23:0];
  end

  // Unmapped addresses read as zero.
  always_comb begin
    read_word = '0;
    if (ADDR == cfmon_pkg::OFF_STATUS) read_word[ND-1:0] = live;
    else if (ADDR == cfmon_pkg::OFF_NOTIFY) read_word[ND-1:0] = notify;
    else if (ADDR == cfmon_pkg::OFF_NOTIFY_EN) read_word[ND-1:0] = notify_en;
    else if (ADDR == cfmon_pkg::OFF_INT_MASK) read_word[ND-1:0] = int_mask;
    else if (ADDR == cfmon_pkg::OFF_ALARM0) read_word = alarm_cfg[0];
    else if (ADDR == cfmon_pkg::OFF_ALARM1) read_word = alarm_cfg[1];
    else if (ADDR == cfmon_pkg::OFF_VALTIME) read_word[9:0] = valtime;
    else if (ADDR == cfmon_pkg::OFF_GOLDEN) read_word[2:0] = golden;
    else if (ADDR == cfmon_pkg::OFF_FD_WIN) read_word[23:0] = fd_win;
    else if (ADDR == cfmon_pkg::OFF_FD_THR) read_word[23:0] = fd_thr;
    else if (ADDR == cfmon_pkg::OFF_LL_WIN) read_word[23:0] = ll_win;
    else if (ADDR == cfmon_pkg::OFF_LL_THR) read_word[5:0] = ll_thr;
    else if (in_cl) read_word = cl_cfg[arr_idx];
    else if (in_exp) read_word[23:0] = fd_exp[arr_idx];
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) RDATA <= '0;
    else if (RD) RDATA <= read_word;
    else RDATA <= '0;
  end

  // Each alarm pin shows one chosen bit or the OR of a masked set.
  generate
    for (genvar a = 0; a < 2; a++) begin : g_alarm
      logic [ND-1:0] src;
      logic [4:0]    sel;
      assign src = alarm_cfg[a][cfmon_pkg::ALM_LIVE] ? live : notify;
      assign sel = alarm_cfg[a][cfmon_pkg::ALM_SEL_LSB +: 5];
      always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) ALARM[a] <= 1'b0;
        else if (alarm_cfg[a][cfmon_pkg::ALM_OR]) ALARM[a] <= |(src & alarm_cfg[a][ND-1:0]);
        else if (sel < 5'(ND)) ALARM[a] <= src[sel];
        else ALARM[a] <= 1'b0;
      end
    end
  endgenerate

  // Fixed pins ignore all selection settings.
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) FIXED_ALARM <= 2'b00;
    else FIXED_ALARM <= {|lock_f, |edge_abs};
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) INT_N <= 1'b1;
    else INT_N <= ~|(notify & int_mask);
  end
endmodule : cfmon_top

// [verification/cfmon_chk.sv]
// Port-level assertions for the clock fault monitor.
`timescale 1ns/1ps
module cfmon_chk (
  // Clock, reset and register port
  input wire logic        CLK_SYS,
  input wire logic        NRST,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  // Pins
  input wire logic [1:0]  ALARM,
  input wire logic [1:0]  FIXED_ALARM,
  input wire logic        INT_N
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  AST_RD_IDLE: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data not zero after idle cycle");
  AST_RD_UNMAP: assert property (RD && ADDR == 8'h60 |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  AST_RST_PINS: assert property ($rose(NRST) |-> INT_N && ALARM == 2'h0 && !FIXED_ALARM)
    else $error("pins not idle after reset");
  AST_INT_UNMASK: assert property (WR && ADDR == cfmon_pkg::OFF_INT_MASK && WDATA == 32'h0
    |-> ##2 INT_N)
    else $error("interrupt low with empty mask");
  AST_INT_HOLD: assert property (!INT_N && !WR && !$past(WR) |=> !INT_N)
    else $error("interrupt released without a write");
  AST_ALM_NONE: assert property (WR && ADDR == cfmon_pkg::OFF_ALARM0 && WDATA == 32'h1f00_0000
    |-> ##2 !ALARM[0])
    else $error("alarm high with select out of range");
  AST_ALM_ORZ: assert property (WR && ADDR == cfmon_pkg::OFF_ALARM1 && WDATA == 32'h8000_0000
    |-> ##2 !ALARM[1])
    else $error("alarm high with empty OR set");
  AST_FIX_QUAL: assert property ($rose(FIXED_ALARM[0]) |-> FIXED_ALARM[0] [*8])
    else $error("fixed loss pin released too soon");
  COV_INT: cover property ($fell(INT_N));
  COV_LOSS: cover property ($rose(FIXED_ALARM[0]));
  COV_LOCK: cover property ($rose(FIXED_ALARM[1]));
endmodule : cfmon_chk
bind cfmon_top cfmon_chk u_chk (.CLK_SYS, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .ALARM,
  .FIXED_ALARM, .INT_N);

// [verification/cfmon_clk_src.sv]
// Behavioural sources for the monitored clocks.
`timescale 1ns/1ps
module cfmon_clk_src (
  // Run controls
  input wire logic [3:0] run_in,
  input wire logic       run_xo,
  input wire logic [3:0] run_fb,
  // Clocks, already divided
  output logic     [3:0] in_clk,
  output logic           xo_clk,
  output logic     [3:0] pll_ref,
  output logic     [3:0] pll_fb
);
  logic osc;
  // A stopped source stands low, as a dead clock would.
  initial begin
    osc = 1'b0;
    forever #100 osc = ~osc;
  end
  assign in_clk  = {4{osc}} & run_in;
  assign xo_clk  = osc & run_xo;
  assign pll_ref = {4{osc}};
  assign pll_fb  = {4{osc}} & run_fb;
endmodule : cfmon_clk_src

// [verification/tb_clock_fault_monitor.sv]
// Register-level testbench for the clock fault monitor.
`timescale 1ns/1ps
module tb_clock_fault_monitor;
  logic        clk_sys;
  logic        nrst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [3:0]  in_clk, pll_ref, pll_fb, run_in, run_fb;
  logic        xo_clk, run_xo, int_n;
  logic [1:0]  alarm, fixed_alarm;
  int          n_fail, checked, cycles;
  // Clk1 edge, fine and coarse drift clk1, lock pll2, oscillator.
  localparam logic [31:0] HIT = 32'h0005_0422;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  // Short qualifying waits keep the run brief.
  cfmon_top #(.VAL_CYC_2MS(26'd20), .VAL_CYC_100MS(26'd40), .VAL_CYC_200MS(26'd60),
    .VAL_CYC_1S(26'd80)) dut (.CLK_SYS(clk_sys), .NRST(nrst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .IN_CLK(in_clk), .XO_CLK(xo_clk), .PLL_REF(pll_ref),
    .PLL_FB(pll_fb), .ALARM(alarm), .FIXED_ALARM(fixed_alarm), .INT_N(int_n));
  cfmon_clk_src src (.run_in(run_in), .run_xo(run_xo), .run_fb(run_fb), .in_clk(in_clk),
    .xo_clk(xo_clk), .pll_ref(pll_ref), .pll_fb(pll_fb));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk(what, rdata & m, exp);
  endtask : rd_chk
  initial begin
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    run_in = 4'hf;
    run_xo = 1'b1;
    run_fb = 4'hf;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    rd_chk("cl_cfg0", cfmon_pkg::OFF_CL_CFG, ALL, 32'h0102_0010);
    rd_chk("notify_rst", cfmon_pkg::OFF_NOTIFY, ALL, 32'h0);
    rd_chk("unmapped", 8'h60, ALL, 32'h0);
    wr_reg(cfmon_pkg::OFF_STATUS, 32'h7_ffff);
    rd_chk("status_ro", cfmon_pkg::OFF_STATUS, ALL, 32'h0);
    wr_reg(cfmon_pkg::OFF_GOLDEN, 32'h0);
    wr_reg(8'h48, 32'd64);
    wr_reg(cfmon_pkg::OFF_FD_WIN, 32'd64);
    wr_reg(cfmon_pkg::OFF_LL_WIN, 32'd32);
    wr_reg(cfmon_pkg::OFF_VALTIME, 32'h0);
    idle(600);
    rd_chk("status_ok", cfmon_pkg::OFF_STATUS, HIT, 32'h0);
    run_in <= 4'hd;
    run_fb <= 4'hb;
    run_xo <= 1'b0;
    idle(600);
    rd_chk("status_bad", cfmon_pkg::OFF_STATUS, HIT, HIT);
    chk("fixed", {30'h0, fixed_alarm}, 32'h3);
    rd_chk("notify_off", cfmon_pkg::OFF_NOTIFY, ALL, 32'h0);
    wr_reg(cfmon_pkg::OFF_NOTIFY_EN, HIT);
    idle(2);
    rd_chk("notify_on", cfmon_pkg::OFF_NOTIFY, ALL, HIT);
    wr_reg(cfmon_pkg::OFF_INT_MASK, 32'h2);
    idle(3);
    chk("int_low", {31'h0, int_n}, 32'h0);
    wr_reg(cfmon_pkg::OFF_ALARM0, 32'h0100_0000);
    wr_reg(cfmon_pkg::OFF_ALARM1, 32'hc000_0002);
    idle(3);
    chk("alarm_on", {30'h0, alarm}, 32'h3);
    wr_reg(cfmon_pkg::OFF_NOTIFY, 32'h2);
    idle(2);
    rd_chk("notify_live", cfmon_pkg::OFF_NOTIFY, HIT, HIT);
    run_in <= 4'hf;
    idle(10);
    rd_chk("qualifying", cfmon_pkg::OFF_STATUS, 32'h2, 32'h2);
    idle(60);
    rd_chk("released", cfmon_pkg::OFF_STATUS, 32'h2, 32'h0);
    rd_chk("notify_kept", cfmon_pkg::OFF_NOTIFY, 32'h2, 32'h2);
    wr_reg(cfmon_pkg::OFF_NOTIFY, 32'h2);
    idle(2);
    rd_chk("notify_clr", cfmon_pkg::OFF_NOTIFY, 32'h2, 32'h0);
    idle(2);
    chk("int_high", {31'h0, int_n}, 32'h1);
    wr_reg(cfmon_pkg::OFF_ALARM0, 32'h1f00_0000);
    wr_reg(cfmon_pkg::OFF_ALARM1, 32'h8000_0000);
    idle(3);
    chk("alarm_off", {30'h0, alarm}, 32'h0);
    wr_reg(cfmon_pkg::OFF_VALTIME, 32'h4);
    run_in <= 4'hd;
    idle(60);
    rd_chk("lost_again", cfmon_pkg::OFF_STATUS, 32'h2, 32'h2);
    chk("int_again", {31'h0, int_n}, 32'h0);
    run_in <= 4'hf;
    idle(30);
    rd_chk("wait_long", cfmon_pkg::OFF_STATUS, 32'h2, 32'h2);
    idle(60);
    rd_chk("released_long", cfmon_pkg::OFF_STATUS, 32'h2, 32'h0);
    wr_reg(cfmon_pkg::OFF_INT_MASK, 32'h0);
    idle(3);
    chk("int_masked", {31'h0, int_n}, 32'h1);
    wrap_up();
  end
endmodule : tb_clock_fault_monitor
